// ---- port_pkg.sv ----
package port_pkg;

	// register byte addresses
	localparam logic [7:0] ADDR_PINS        = 8'h00;
	localparam logic [7:0] ADDR_LATCH       = 8'h04;
	localparam logic [7:0] ADDR_DIRECTION   = 8'h08;
	localparam logic [7:0] ADDR_ANALOG      = 8'h0c;
	localparam logic [7:0] ADDR_OPEN_DRAIN  = 8'h10;
	localparam logic [7:0] ADDR_SLEW        = 8'h14;
	localparam logic [7:0] ADDR_THRESHOLD   = 8'h18;
	localparam logic [7:0] ADDR_ALT_SELECT  = 8'h1c;

	// reset values
	localparam logic [7:0] RST_DIRECTION    = 8'hff;
	localparam logic [7:0] RST_LATCH        = 8'h00;
	localparam logic [7:0] RST_ANALOG       = 8'hbf;
	localparam logic [7:0] RST_OPEN_DRAIN   = 8'h00;
	localparam logic [7:0] RST_SLEW         = 8'hff;
	localparam logic [7:0] RST_THRESHOLD    = 8'h00;
	localparam logic [7:0] RST_ALT_SELECT   = 8'h00;
	localparam logic [7:0] ANALOG_IMPL_MASK = 8'hbf;

	// alt_pin_select field positions
	localparam int SEL_COMPARATOR2 = 7;
	localparam int SEL_CAPTURE1    = 6;
	localparam int SEL_SERIAL_OUT  = 5;
	localparam int SEL_SERIAL_CLK  = 4;
	localparam int SEL_SERIAL_DATA = 3;
	localparam int SEL_UART_TX     = 2;
	localparam int SEL_UART_RX     = 1;
	localparam int SEL_CAPTURE2    = 0;

	// alternate-function pin slots: second port 0,3,5,6,7 then third port 1..7
	localparam int NUM_ALT_PINS = 12;
	localparam int P_B0 = 0;
	localparam int P_B3 = 1;
	localparam int P_B5 = 2;
	localparam int P_B6 = 3;
	localparam int P_B7 = 4;
	localparam int P_C1 = 5;
	localparam int P_C2 = 6;
	localparam int P_C3 = 7;
	localparam int P_C4 = 8;
	localparam int P_C5 = 9;
	localparam int P_C6 = 10;
	localparam int P_C7 = 11;

	// pin positions with peripheral outputs
	localparam int PIN_OPAMP  = 1;
	localparam int PIN_DAC    = 2;
	localparam int PIN_CMP1   = 4;
	localparam int PIN_CMP2_A = 5;
	localparam int PIN_CMP2_B = 6;

	typedef enum logic [1:0] {
		APB_IDLE   = 2'b00,
		APB_ACCESS = 2'b01
	} apb_state_t;

endpackage : port_pkg

// ---- periph_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface periph_if;
	import port_pkg::*;
	// one bundle per peripheral signal: output value, output enable, input seen
	logic [7:0]              func_out;
	logic [7:0]              func_oe;
	logic [7:0]              func_in;
	logic [7:0]              sel;
	logic [NUM_ALT_PINS-1:0] pin_in;
	logic [NUM_ALT_PINS-1:0] pin_out;
	logic [NUM_ALT_PINS-1:0] pin_oe;
	logic [NUM_ALT_PINS-1:0] pin_claim;

	modport router (input func_out, func_oe, sel, pin_in, output func_in, pin_out, pin_oe, pin_claim);
	modport owner  (output func_out, func_oe, sel, pin_in, input func_in, pin_out, pin_oe, pin_claim);
endinterface : periph_if
`default_nettype wire

// ---- alt_pin_router.sv ----
`timescale 1ns/1ns
`default_nettype none
module alt_pin_router
	import port_pkg::*;
(
	periph_if.router bus
);
	// func index order matches alt_pin_select bit positions
	localparam int PIN_ONE  [8] = '{P_B3, P_B7, P_B6, P_B6, P_B7, P_B5, P_B0, 0};
	localparam int PIN_ZERO [8] = '{P_C1, P_C7, P_C6, P_C4, P_C3, P_C5, P_C2, 0};

	always_comb begin
		bus.pin_out   = '0;
		bus.pin_oe    = '0;
		bus.pin_claim = '0;
		bus.func_in   = '0;
		// bit 7 targets first-port pins and is handled in the port itself
		for (int f = 0; f < 7; f++) begin
			if (bus.sel[f]) begin
				bus.pin_claim[PIN_ONE[f]] = 1'b1;
				bus.pin_oe[PIN_ONE[f]]    = bus.pin_oe[PIN_ONE[f]] | bus.func_oe[f];
				bus.pin_out[PIN_ONE[f]]   = bus.pin_out[PIN_ONE[f]] | (bus.func_oe[f] & bus.func_out[f]);
				bus.func_in[f]            = bus.pin_in[PIN_ONE[f]];
			end else begin
				bus.pin_claim[PIN_ZERO[f]] = 1'b1;
				bus.pin_oe[PIN_ZERO[f]]    = bus.pin_oe[PIN_ZERO[f]] | bus.func_oe[f];
				bus.pin_out[PIN_ZERO[f]]   = bus.pin_out[PIN_ZERO[f]] | (bus.func_oe[f] & bus.func_out[f]);
				bus.func_in[f]             = bus.pin_in[PIN_ZERO[f]];
			end
		end
	end
endmodule : alt_pin_router
`default_nettype wire

// ---- input_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module input_sync #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} sync_state_t;

	sync_state_t state_ff;
	sync_state_t nxt_state;

	always_comb begin
		nxt_state.stage1 = async_in;
		nxt_state.stage2 = state_ff.stage1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign sync_out = state_ff.stage2;
endmodule : input_sync
`default_nettype wire

// ---- port_pin_steering_gpio.sv ----
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - alt select bit 7 puts comparator 2 on pin6 when 1, pin5 when 0.
// - bit 6 puts capture unit 1 on second-port pin0 or third-port pin2.
// - bit 5 puts serial data out on second-port pin5 or third-port pin5.
// - bit 4 puts serial clock on second-port pin7 or third-port pin3.
// - bit 3 puts serial data in/out on second-port pin6 or third-port pin4.
// - bit 2 puts uart transmit on second-port pin6 or third-port pin6.
// - bit 1 puts uart receive on second-port pin7 or third-port pin7.
// - bit 0 puts capture unit 2 on second-port pin3 or third-port pin1.
// - selection never touches direction bits; overrides follow the chosen pin only.
// - direction 1 makes a pin input, 0 drives the output latch.
// - port read returns sampled pins; port write updates the latch.
// - port write replaces the whole latch byte with the written data.
// - direction bits gate drivers even on analog pins.
// - analog-selected pins read as zero digitally.
// - per-pin open-drain bit: sink only when set, push-pull when clear.
// - per-pin slew bit limits slew rate when set.
// - per-pin threshold choice applies to port reads and change detection.
// - analog select does not affect digital output drive.
// - analog select bits reset to analog mode, except bit 6, which resets to 0.
// - highest-priority enabled output source controls the pin, even in analog mode.
// - priorities: opamp, dac, comparator1, comparator2, clock-out over comparator2, else latch.
// - threshold bit 1 selects Schmitt, 0 selects TTL.
// - latch read returns latch; writes to port or latch update the latch.
module port_pin_steering_gpio
	import port_pkg::*;
(
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// first port pads
	input  wire logic [7:0]  pad_in,
	output logic      [7:0]  pad_out,
	output logic      [7:0]  pad_oe,
	output logic      [7:0]  pad_slew_limit,
	output logic      [7:0]  pad_schmitt,
	output logic      [7:0]  pad_analog_enable,
	// other-port pads for steered functions: B0,B3,B5,B6,B7,C1..C7
	input  wire logic [11:0] alt_pad_in,
	output logic      [11:0] alt_pad_out,
	output logic      [11:0] alt_pad_oe,
	output logic      [11:0] alt_pad_claim,
	// analog and clock peripheral outputs
	input  wire logic        opamp1_output,
	input  wire logic        opamp1_enable,
	input  wire logic        dac_output,
	input  wire logic        dac_enable,
	input  wire logic        comparator1_output,
	input  wire logic        comparator1_enable,
	input  wire logic        comparator2_output,
	input  wire logic        comparator2_enable,
	input  wire logic        clock_output,
	input  wire logic        clock_output_enable,
	// steered digital peripherals, bit order as alt_pin_select bits 6..0
	input  wire logic [6:0]  steered_out,
	input  wire logic [6:0]  steered_oe,
	output logic      [6:0]  steered_in,
	// first-port levels for peripherals and change detection
	output logic      [7:0]  port_level
);
	typedef struct packed {
		apb_state_t  apb;
		logic [7:0]  direction;
		logic [7:0]  latch;
		logic [7:0]  analog;
		logic [7:0]  open_drain;
		logic [7:0]  slew;
		logic [7:0]  threshold;
		logic [7:0]  alt_select;
		logic [31:0] rdata;
		logic        err;
	} gpio_state_t;

	gpio_state_t state_ff;
	gpio_state_t nxt_state;

	logic [7:0]  pins_sync;
	logic [11:0] alt_sync;
	logic [7:0]  pin_read;
	logic [7:0]  drive_val;
	logic [7:0]  periph_oe;
	logic [7:0]  periph_val;
	logic        cmp2_on_pin6;
	logic        mapped;
	logic [7:0]  wbyte;

	periph_if steer ();

	input_sync #(
		.WIDTH(8)
	) u_pin_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (pad_in),
		.sync_out (pins_sync)
	);

	input_sync #(
		.WIDTH(NUM_ALT_PINS)
	) u_alt_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (alt_pad_in),
		.sync_out (alt_sync)
	);

	alt_pin_router u_router (
		.bus (steer.router)
	);

	assign steer.sel      = state_ff.alt_select;
	assign steer.func_out = {1'b0, steered_out};
	assign steer.func_oe  = {1'b0, steered_oe};
	assign steer.pin_in   = alt_sync;
	assign alt_pad_out    = steer.pin_out;
	assign alt_pad_oe     = steer.pin_oe;
	assign alt_pad_claim  = steer.pin_claim;
	assign steered_in     = steer.func_in[6:0];

	// digital input: analog pins read zero; threshold choice drives the pad buffer
	assign pin_read          = pins_sync & ~state_ff.analog;
	assign port_level        = pin_read;
	assign pad_schmitt       = state_ff.threshold;
	assign pad_slew_limit    = state_ff.slew;
	assign pad_analog_enable = state_ff.analog;

	assign cmp2_on_pin6 = state_ff.alt_select[SEL_COMPARATOR2];

	// output priority per pin
	always_comb begin
		periph_oe  = '0;
		periph_val = '0;
		periph_oe[PIN_OPAMP]  = opamp1_enable;
		periph_val[PIN_OPAMP] = opamp1_output;
		periph_oe[PIN_DAC]    = dac_enable;
		periph_val[PIN_DAC]   = dac_output;
		periph_oe[PIN_CMP1]   = comparator1_enable;
		periph_val[PIN_CMP1]  = comparator1_output;
		periph_oe[PIN_CMP2_A]  = comparator2_enable & ~cmp2_on_pin6;
		periph_val[PIN_CMP2_A] = comparator2_output;
		if (clock_output_enable) begin
			periph_oe[PIN_CMP2_B]  = 1'b1;
			periph_val[PIN_CMP2_B] = clock_output;
		end else begin
			periph_oe[PIN_CMP2_B]  = comparator2_enable & cmp2_on_pin6;
			periph_val[PIN_CMP2_B] = comparator2_output;
		end
	end

	// drivers: direction gates all digital outputs, analog select is ignored here
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			drive_val[i] = periph_oe[i] ? periph_val[i] : state_ff.latch[i];
			pad_out[i]   = drive_val[i];
			if (state_ff.direction[i]) begin
				pad_oe[i] = 1'b0;
			end else if (state_ff.open_drain[i]) begin
				pad_oe[i] = ~drive_val[i];
			end else begin
				pad_oe[i] = 1'b1;
			end
		end
	end

	// apb register file
	assign wbyte  = pwdata[7:0];
	assign mapped = (paddr[1:0] == 2'b00) && (paddr <= ADDR_ALT_SELECT);

	always_comb begin
		nxt_state = state_ff;
		case (state_ff.apb)
			APB_IDLE: begin
				if (psel && !penable) begin
					nxt_state.apb   = APB_ACCESS;
					nxt_state.err   = !mapped;
					nxt_state.rdata = '0;
					case (paddr)
						ADDR_PINS:       nxt_state.rdata[7:0] = pin_read;
						ADDR_LATCH:      nxt_state.rdata[7:0] = state_ff.latch;
						ADDR_DIRECTION:  nxt_state.rdata[7:0] = state_ff.direction;
						ADDR_ANALOG:     nxt_state.rdata[7:0] = state_ff.analog;
						ADDR_OPEN_DRAIN: nxt_state.rdata[7:0] = state_ff.open_drain;
						ADDR_SLEW:       nxt_state.rdata[7:0] = state_ff.slew;
						ADDR_THRESHOLD:  nxt_state.rdata[7:0] = state_ff.threshold;
						ADDR_ALT_SELECT: nxt_state.rdata[7:0] = state_ff.alt_select;
						default:         nxt_state.rdata = '0;
					endcase
				end
			end
			APB_ACCESS: begin
				nxt_state.apb = APB_IDLE;
				if (psel && penable && pwrite) begin
					case (paddr)
						// whole byte lands in the latch; unwritten bits are none since a write covers all 8
						ADDR_PINS:       nxt_state.latch      = wbyte;
						ADDR_LATCH:      nxt_state.latch      = wbyte;
						ADDR_DIRECTION:  nxt_state.direction  = wbyte;
						ADDR_ANALOG:     nxt_state.analog     = wbyte & ANALOG_IMPL_MASK;
						ADDR_OPEN_DRAIN: nxt_state.open_drain = wbyte;
						ADDR_SLEW:       nxt_state.slew       = wbyte;
						ADDR_THRESHOLD:  nxt_state.threshold  = wbyte;
						ADDR_ALT_SELECT: nxt_state.alt_select = wbyte;
						default:         nxt_state.err        = 1'b1;
					endcase
				end
			end
			default: nxt_state.apb = APB_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff.apb        <= APB_IDLE;
			state_ff.direction  <= RST_DIRECTION;
			state_ff.latch      <= RST_LATCH;
			state_ff.analog     <= RST_ANALOG;
			state_ff.open_drain <= RST_OPEN_DRAIN;
			state_ff.slew       <= RST_SLEW;
			state_ff.threshold  <= RST_THRESHOLD;
			state_ff.alt_select <= RST_ALT_SELECT;
			state_ff.rdata      <= '0;
			state_ff.err        <= 1'b0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign pready  = (state_ff.apb == APB_ACCESS);
	assign prdata  = pready ? state_ff.rdata : 32'h0000_0000;
	assign pslverr = pready & state_ff.err;
endmodule : port_pin_steering_gpio
`default_nettype wire

// ---- gpio_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module gpio_monitor
	import port_pkg::*;
(
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// register bus
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	// first port
	input wire logic [7:0]  pad_in,
	input wire logic [7:0]  pad_out,
	input wire logic [7:0]  pad_analog_enable,
	input wire logic [7:0]  port_level,
	// peripherals and steered pins
	input wire logic        opamp1_output,
	input wire logic        opamp1_enable,
	input wire logic        clock_output,
	input wire logic        clock_output_enable,
	input wire logic [6:0]  steered_out,
	input wire logic [6:0]  steered_oe,
	input wire logic [11:0] alt_pad_out,
	input wire logic [11:0] alt_pad_claim
);
	logic [1:0] up_ff;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// edges since reset, so the input sync pipe holds real samples
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			up_ff <= 2'h0;
		else if (up_ff != 2'h3)
			up_ff <= up_ff + 2'h1;
	end
	property p_ready_pulse;
		psel && !penable |=> pready ##1 !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready not one cycle after setup");
	property p_opamp_first;
		opamp1_enable |-> pad_out[PIN_OPAMP] == opamp1_output;
	endproperty
	a_opamp_first: assert property (p_opamp_first) else $error("op-amp output lost pin1");
	property p_clock_output_first;
		clock_output_enable |-> pad_out[PIN_CMP2_B] == clock_output;
	endproperty
	a_clock_output_first: assert property (p_clock_output_first) else $error("clock-out lost pin6");
	property p_analog_zero;
		(port_level & pad_analog_enable) == 8'h00;
	endproperty
	a_analog_zero: assert property (p_analog_zero) else $error("analog pin reads one");
	property p_pin_lag;
		up_ff == 2'h3 && $stable(pad_analog_enable) |-> port_level == ($past(pad_in, 2) & ~pad_analog_enable);
	endproperty
	a_pin_lag: assert property (p_pin_lag) else $error("pin level not two edges behind pad");
	property p_serial_out_one;
		alt_pad_claim[P_B5] != alt_pad_claim[P_C5];
	endproperty
	a_serial_out_one: assert property (p_serial_out_one) else $error("serial out not on exactly one pin");
	property p_capture2_route;
		alt_pad_claim[P_B3] |-> alt_pad_out[P_B3] == (steered_out[0] & steered_oe[0]) && !alt_pad_claim[P_C1];
	endproperty
	a_capture2_route: assert property (p_capture2_route) else $error("capture 2 misrouted");
	property p_capture1_move;
		$rose(alt_pad_claim[P_B0]) |-> $fell(alt_pad_claim[P_C2]) && alt_pad_out[P_B0] == (steered_out[6] & steered_oe[6]);
	endproperty
	a_capture1_move: assert property (p_capture1_move) else $error("capture 1 did not move");
endmodule : gpio_monitor
bind port_pin_steering_gpio gpio_monitor i_gpio_monitor (.pclk, .presetn, .psel, .penable, .pready, .pad_in,
	.pad_out, .pad_analog_enable, .port_level, .opamp1_output, .opamp1_enable, .clock_output,
	.clock_output_enable, .steered_out, .steered_oe, .alt_pad_out, .alt_pad_claim);
`default_nettype wire

// ---- board_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module board_model (
	// device drive
	input  wire logic [7:0]  pad_out,
	input  wire logic [7:0]  pad_oe,
	input  wire logic [11:0] alt_pad_out,
	input  wire logic [11:0] alt_pad_oe,
	// outside drivers and pulls
	input  wire logic [7:0]  ext_level,
	input  wire logic [11:0] alt_ext_level,
	// levels on the board
	output logic      [7:0]  pad_in,
	output logic      [11:0] alt_pad_in
);
	// an undriven pin shows whatever the board puts on it
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
	assign alt_pad_in = (alt_pad_oe & alt_pad_out) | (~alt_pad_oe & alt_ext_level);
endmodule : board_model
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import port_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, pad_out, pad_oe, pad_slew, pad_st, pad_an, pad_in, port_level, ext;
	logic [31:0] pwdata, prdata, seed, rd;
	logic [11:0] a_out, a_oe, a_claim, a_in, a_ext;
	logic [9:0]  pv;
	logic [6:0]  s_out, s_oe, s_in;
	logic [7:0]  rg [8];
	int          n_fail, total_checks;
	localparam int HI [7] = '{P_B3, P_B7, P_B6, P_B6, P_B7, P_B5, P_B0};
	localparam int LO [7] = '{P_C1, P_C7, P_C6, P_C4, P_C3, P_C5, P_C2};
	port_pin_steering_gpio i_port_pin_steering_gpio (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .pad_in, .pad_out, .pad_oe, .pad_slew_limit(pad_slew),
		.pad_schmitt(pad_st), .pad_analog_enable(pad_an), .alt_pad_in(a_in), .alt_pad_out(a_out),
		.alt_pad_oe(a_oe), .alt_pad_claim(a_claim), .opamp1_output(pv[0]), .opamp1_enable(pv[1]),
		.dac_output(pv[2]), .dac_enable(pv[3]), .comparator1_output(pv[4]), .comparator1_enable(pv[5]),
		.comparator2_output(pv[6]), .comparator2_enable(pv[7]), .clock_output(pv[8]),
		.clock_output_enable(pv[9]), .steered_out(s_out), .steered_oe(s_oe), .steered_in(s_in), .port_level);
	board_model i_board_model (.pad_out, .pad_oe, .alt_pad_out(a_out), .alt_pad_oe(a_oe),
		.ext_level(ext), .alt_ext_level(a_ext), .pad_in, .alt_pad_in(a_in));
	always #20 pclk = ~pclk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int   n;
		logic bad;
		bad = (a > ADDR_ALT_SELECT) || (a[1:0] != 2'b00);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		// answer and read data are taken at the rising edge that sees pready high
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_fail++;
			$display("MISMATCH t=%0t register bus gave no answer", $time);
			results();
		end
		rd = prdata;
		chk(32'(pslverr), 32'(bad), "slave error");
		{psel, penable} <= 2'b00;
		if (w && !bad)
			rg[a == ADDR_PINS ? 3'd1 : a[4:2]] = d[7:0] & (a == ADDR_ANALOG ? ANALOG_IMPL_MASK : 8'hff);
	endtask : apb
	task automatic check_all();
		logic [7:0]  o, oe, lv;
		logic [11:0] ao, ae, cl, al;
		logic [6:0]  si;
		int          s;
		o = rg[1];
		if (pv[1]) o[1] = pv[0];
		if (pv[3]) o[2] = pv[2];
		if (pv[5]) o[4] = pv[4];
		if (pv[7] && !rg[7][7]) o[5] = pv[6];
		if (pv[7] && rg[7][7]) o[6] = pv[6];
		if (pv[9]) o[6] = pv[8];
		oe = ~rg[2] & (~rg[4] | ~o);
		lv = (oe & o) | (~oe & ext);
		{ao, ae, cl} = '0;
		for (int i = 0; i < 7; i++) begin
			s = rg[7][i] ? HI[i] : LO[i];
			ao[s] |= s_out[i] & s_oe[i];
			ae[s] |= s_oe[i];
			cl[s] = 1'b1;
		end
		al = (ae & ao) | (~ae & a_ext);
		for (int i = 0; i < 7; i++) si[i] = al[rg[7][i] ? HI[i] : LO[i]];
		chk(32'(pad_out), 32'(o), "pad value");
		chk(32'(pad_oe), 32'(oe), "pad enable");
		chk(32'(pad_slew), 32'(rg[5]), "slew");
		chk(32'(pad_st), 32'(rg[6]), "threshold");
		chk(32'(pad_an), 32'(rg[3]), "analog");
		chk(32'(a_out), 32'(ao), "steered value");
		chk(32'(a_oe), 32'(ae), "steered enable");
		chk(32'(a_claim), 32'(cl), "pin claim");
		chk(32'(s_in), 32'(si), "steered input");
		chk(32'(port_level), 32'(lv & ~rg[3]), "level");
		apb(1'b0, ADDR_PINS, 32'h0);
		chk(rd, 32'(lv & ~rg[3]), "pin read");
		apb(1'b0, ADDR_LATCH, 32'h0);
		chk(rd, 32'(rg[1]), "latch read");
		apb(1'b0, ADDR_DIRECTION, 32'h0);
		chk(rd, 32'(rg[2]), "direction kept");
	endtask : check_all
	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		results();
	end
	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{pv, s_out, s_oe, ext, a_ext} = '0;
		{seed, n_fail, total_checks} = {32'h8db0f075, 64'h0};
		rg = '{8'h00, RST_LATCH, RST_DIRECTION, RST_ANALOG, RST_OPEN_DRAIN, RST_SLEW, RST_THRESHOLD, RST_ALT_SELECT};
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 4; a < 36; a += 4) begin
			apb(1'b0, 8'(a), 32'h0);
			chk(rd, (a < 32) ? 32'(rg[a / 4]) : 32'h0, "reset value");
		end
		apb(1'b1, 8'h22, 32'hff);
		// threshold changed while every peripheral is still off
		apb(1'b1, ADDR_THRESHOLD, 32'hffff_ffa5);
		for (int it = 0; it < 40; it++) begin
			// peripherals quiet while the threshold register may be rewritten
			{pv, s_oe} <= '0;
			seed = lfsr(seed);
			apb(1'b1, it[0] ? ADDR_PINS : ADDR_LATCH, seed);
			foreach (HI[j]) begin
				seed = lfsr(seed);
				if (j < 5)
					apb(1'b1, 8'(8 + 4 * j), seed);
			end
			seed = lfsr(seed);
			apb(1'b1, ADDR_ALT_SELECT, seed);
			@(posedge pclk);
			seed = lfsr(seed);
			{pv, s_out, s_oe, ext} <= seed;
			seed = lfsr(seed);
			a_ext <= seed[11:0];
			repeat (3) @(posedge pclk);
			@(negedge pclk);
			check_all();
		end
		results();
	end
endmodule : tb_top
`default_nettype wire
